/* pkg/mal_pkg.sv */
// Shared constants and types of the measurement alert logic.
// Assumes one 40 MHz clock and a register access port fed by an external serial engine.
`default_nettype none
package mal_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_CH  = 4;
    localparam int NUM_PAR = 5;
    localparam int CAUSE_W = 8;
    localparam int CNT_W   = 5;
    localparam logic [4:0] CNT_MAX = 5'h10;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_BUS_SET  = 8'h1C;
    localparam logic [7:0] OFF_CAUSE    = 8'h20;
    localparam logic [7:0] OFF_ROUTE1   = 8'h21;
    localparam logic [7:0] OFF_ROUTE2   = 8'h22;
    localparam logic [7:0] OFF_CTRL     = 8'h23;
    localparam logic [7:0] OFF_LIM_EN   = 8'h24;
    localparam logic [7:0] OFF_COUNTS   = 8'h25;
    localparam logic [7:0] OFF_FULL_SEL = 8'h26;
    localparam logic [2:0] LIMIT_PAGE   = 3'h2;

    // ==========================================================
    // Field positions
    localparam int BS_ALERT   = 5;
    localparam int BS_GPO     = 6;
    localparam int BS_GPI     = 7;
    localparam int CT_CC1     = 0;
    localparam int CT_CC2     = 1;
    localparam int CT_P1ALERT = 2;
    localparam int CT_P2GPIO  = 3;
    localparam int CT_P2DIR   = 4;
    localparam int CT_BURST   = 5;
    localparam int CB_ACCF    = 5;
    localparam int CB_CNTF    = 6;
    localparam int CB_OVF     = 7;
    localparam logic [31:0] OVF_MASK = 32'h80808080;

    // ==========================================================
    // Reset values
    localparam logic [31:0] ROUTE_RST = 32'h00000000;
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [19:0] LIMEN_RST = 20'h00000;
    localparam logic [19:0] COUNT_RST = 20'h00000;
    localparam logic [15:0] FULL_RST  = 16'h0000;

    // ==========================================================
    // Sample kinds and fullness selections
    localparam logic [1:0] KIND_VBUS   = 2'h0;
    localparam logic [1:0] KIND_VSENSE = 2'h1;
    localparam logic [1:0] KIND_POWER  = 2'h2;
    localparam logic [1:0] FULL_15_16  = 2'h0;
    localparam logic [1:0] FULL_7_8    = 2'h1;
    localparam logic [1:0] FULL_3_4    = 2'h2;

    // ==========================================================
    // Timing
    localparam int CLK_NS       = 25;
    localparam int CC_PULSE_NS  = 5000;
    localparam int CC_PULSE_CYC = (CC_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] CC_PULSE_LD = 8'(CC_PULSE_CYC);

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } mal_regreq_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  ch;
        logic [1:0]  kind;
        logic [23:0] value;
    } mal_sample_t;

    typedef struct packed {
        logic [3:0] accTop;
        logic       accSat;
        logic [3:0] cntTop;
        logic       cntSat;
    } mal_accfill_t;
endpackage
`default_nettype wire

/* rtl/mal_alert_top.sv */
// Alert logic of a four-channel power monitor: limit checks, fullness, cause register, alert pins.
// Assumes a sequencer on mclk that sends samples and a cycle-end strobe, and a register port
// decoded by an external serial engine, which also delivers refresh commands as pulses.
//
// How it works
// - Every source but cycle-done holds its alert pin low until cleared.
// - Cycle-done enable per output pulses that output low 5 us per cycle.
// - Detected conditions enter the cause register only at cycle end.
// - No cycle-done pulse in burst mode with one active channel.
// - Cycle-done pulse never sets a cause bit.
// - Route masks send each source but cycle-done to output one, two or both.
// - Slow input of pin one ignored while it serves as alert.
// - General alert flag is bit 5 of register 1Ch, live.
// - Pin two as I/O: input read through two synchroniser stages, output bit driven one cycle after its write.
// - Per-channel enable per check; disabled checks never alert.
// - Limits and samples compared as two's complement.
// - 16-bit voltage and current limits, 24-bit power limit per channel.
// - Over-limit sample count 1..16 per parameter, default 1.
// - High checks trip above limit, low checks below limit.
// - Power check uses magnitude of the power sample.
// - Fullness threshold 15/16, 7/8, 3/4 or full per channel.
// - Reading the cause register clears all but its overflow bits and releases their alerts.
// - Cause register updates without any refresh command.
// - Overflow cause held until full or general refresh.
// - Persisting condition reasserts on the next violating sample.
`timescale 1ns/10ps
`default_nettype none
module mal_alert_top
(
    // Clock and reset
    input  wire  logic                              mclk,
    input  wire  logic                              arst_n,
    // Register port
    input  wire  mal_pkg::mal_regreq_t              regReq,
    output logic [31:0]                             regRdData,
    // Sequencer
    input  wire  mal_pkg::mal_sample_t              sample,
    input  wire  logic                              cycleEnd,
    input  wire  logic [2:0]                        activeChannels,
    input  wire  mal_pkg::mal_accfill_t [3:0]       accFill,
    // Refresh commands
    input  wire  logic                              refreshFull,
    input  wire  logic                              refreshGeneral,
    // Pins
    input  wire  logic                              slowOrEventOut1In,
    output logic                                    slowOrEventOut1Out,
    output logic                                    slowOrEventOut1Oe,
    input  wire  logic                              ioOrEventOut2In,
    output logic                                    ioOrEventOut2Out,
    output logic                                    ioOrEventOut2Oe,
    output logic                                    slowRequest
);
    import mal_pkg::*;

    typedef struct packed {
        logic [31:0]  cause;
        logic [31:0]  pend;
        logic [31:0]  route1;
        logic [31:0]  route2;
        logic [7:0]   ctrl;
        logic [19:0]  limEn;
        logic [19:0]  counts;
        logic [15:0]  fullSel;
        logic         gpo;
        logic [31:0]  rdData;
        logic [99:0]  overCnt;
        logic [7:0]   ccCnt;
        mal_sample_t  smp1;
        logic [1:0]   p1Sync;
        logic [1:0]   p2Sync;
        logic         drv1;
        logic         drv2;
    } mal_top_st_t;

    mal_top_st_t q;
    mal_top_st_t d;
    logic [31:0] setMask;
    logic [31:0] clrMask;
    logic [31:0] hitVec;
    logic [23:0] limHi;
    logic [23:0] limLo;
    logic        memWe;
    logic        ccActive;
    logic        singleBurst;
    logic        alert1Lvl;
    logic        alert2Lvl;

    // ==========================================================
    // Decoding helpers
    function automatic logic [1:0] parKind(input int p);
        if (p < 2)
            return KIND_VBUS;
        else if (p < 4)
            return KIND_VSENSE;
        else
            return KIND_POWER;
    endfunction

    function automatic logic violates(input int p, input logic [23:0] v, input logic [23:0] hi,
                                      input logic [23:0] lo);
        logic signed [24:0] mag;
        mag = v[23] ? -$signed({v[23], v}) : $signed({v[23], v});
        case (p)
            0, 2:    return $signed(v) > $signed(hi);
            1, 3:    return $signed(v) < $signed(lo);
            default: return mag > $signed({hi[23], hi});
        endcase
    endfunction

    function automatic logic fillReached(input logic [3:0] top, input logic sat, input logic [1:0] sel);
        case (sel)
            FULL_15_16: return &top;
            FULL_7_8:   return &top[3:1];
            FULL_3_4:   return &top[3:2];
            default:    return sat;
        endcase
    endfunction

    // ==========================================================
    // Limit store, read with the sample so limits line up with smp1
    mal_limit_mem u_mem
    (
        .mclk   (mclk),
        .arst_n (arst_n),
        .wrEn   (memWe),
        .wrAddr (regReq.addr[4:0]),
        .wrData (regReq.addr[2:1] == KIND_POWER ? regReq.wdata[23:0]
                                                : {{8{regReq.wdata[15]}}, regReq.wdata[15:0]}),
        .rdEn   (sample.valid),
        .rdAddr ({sample.ch, sample.kind}),
        .rdHi   (limHi),
        .rdLo   (limLo)
    );

    assign memWe       = regReq.wrEn && regReq.addr[7:5] == LIMIT_PAGE;
    assign ccActive    = q.ccCnt != 8'h00;
    assign singleBurst = q.ctrl[CT_BURST] && activeChannels == 3'h1;
    assign alert1Lvl   = |(q.cause & q.route1) || (ccActive && q.ctrl[CT_CC1]);
    assign alert2Lvl   = |(q.cause & q.route2) || (ccActive && q.ctrl[CT_CC2]);

    // ==========================================================
    // Next state
    always_comb
    begin
        int          idx;
        logic [4:0]  oldCnt;
        logic [4:0]  newCnt;
        idx     = 0;
        oldCnt  = '0;
        newCnt  = '0;
        d       = q;
        setMask = '0;
        clrMask = '0;
        hitVec  = '0;

        d.p1Sync = {q.p1Sync[0], slowOrEventOut1In};
        d.p2Sync = {q.p2Sync[0], ioOrEventOut2In};
        d.smp1   = sample;

        // Limit checks on the sample of the previous cycle
        for (int p = 0; p < NUM_PAR; p++)
        begin
            if (q.smp1.valid && q.smp1.kind == parKind(p))
            begin
                idx    = int'(q.smp1.ch) * NUM_PAR + p;
                oldCnt = q.overCnt[idx*CNT_W +: CNT_W];
                if (q.limEn[idx] && violates(p, q.smp1.value, limHi, limLo))
                begin
                    newCnt = (oldCnt == CNT_MAX) ? oldCnt : oldCnt + 5'h01;
                    // Saturated counter keeps firing, so a cleared cause comes back next sample
                    if (newCnt > {1'b0, q.counts[p*4 +: 4]})
                        hitVec[int'(q.smp1.ch)*CAUSE_W + p] = 1'b1;
                end
                else
                begin
                    newCnt = '0;
                end
                d.overCnt[idx*CNT_W +: CNT_W] = newCnt;
            end
        end

        // Conditions gather during the cycle and land in the cause register at its end
        if (cycleEnd)
        begin
            setMask = q.pend | hitVec;
            for (int c = 0; c < NUM_CH; c++)
            begin
                setMask[c*CAUSE_W + CB_ACCF] = fillReached(accFill[c].accTop, accFill[c].accSat,
                                                           q.fullSel[c*4 +: 2]);
                setMask[c*CAUSE_W + CB_CNTF] = fillReached(accFill[c].cntTop, accFill[c].cntSat,
                                                           q.fullSel[c*4+2 +: 2]);
                setMask[c*CAUSE_W + CB_OVF]  = accFill[c].accSat || accFill[c].cntSat;
            end
            d.pend = '0;
        end
        else
        begin
            d.pend = q.pend | hitVec;
        end

        // Register reads, data registered for one cycle later
        if (regReq.rdEn)
        begin
            case (regReq.addr)
                OFF_BUS_SET:  d.rdData = {24'h000000, q.p2Sync[1], q.gpo, |q.cause, 5'h00};
                OFF_CAUSE:    d.rdData = q.cause;
                OFF_ROUTE1:   d.rdData = q.route1;
                OFF_ROUTE2:   d.rdData = q.route2;
                OFF_CTRL:     d.rdData = {24'h000000, q.ctrl};
                OFF_LIM_EN:   d.rdData = {12'h000, q.limEn};
                OFF_COUNTS:   d.rdData = {12'h000, q.counts};
                OFF_FULL_SEL: d.rdData = {16'h0000, q.fullSel};
                default:      d.rdData = 32'h00000000;
            endcase
            if (regReq.addr == OFF_CAUSE)
                clrMask = ~OVF_MASK;
        end
        // Overflow survives a cause read; only these refreshes drop it
        if (refreshFull || refreshGeneral)
            clrMask = clrMask | OVF_MASK;
        // Set wins over clear so an event at the read is kept
        d.cause = (q.cause & ~clrMask) | setMask;

        // Register writes
        if (regReq.wrEn)
        begin
            case (regReq.addr)
                OFF_BUS_SET:  d.gpo     = regReq.wdata[BS_GPO];
                OFF_ROUTE1:   d.route1  = regReq.wdata;
                OFF_ROUTE2:   d.route2  = regReq.wdata;
                OFF_CTRL:     d.ctrl    = regReq.wdata[7:0];
                OFF_LIM_EN:   d.limEn   = regReq.wdata[19:0];
                OFF_COUNTS:   d.counts  = regReq.wdata[19:0];
                OFF_FULL_SEL: d.fullSel = regReq.wdata[15:0];
                default:      d.gpo     = q.gpo;
            endcase
        end

        // Cycle-done pulse: a counter, no cause bit involved
        if (cycleEnd && !singleBurst)
            d.ccCnt = CC_PULSE_LD;
        else if (ccActive)
            d.ccCnt = q.ccCnt - 8'h01;

        // Pin drive, open drain: enable high pulls the pin low
        d.drv1 = q.ctrl[CT_P1ALERT] && alert1Lvl;
        if (q.ctrl[CT_P2GPIO])
            d.drv2 = q.ctrl[CT_P2DIR] && !q.gpo;
        else
            d.drv2 = alert2Lvl;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q         <= '0;
            q.route1  <= ROUTE_RST;
            q.route2  <= ROUTE_RST;
            q.ctrl    <= CTRL_RST;
            q.limEn   <= LIMEN_RST;
            q.counts  <= COUNT_RST;
            q.fullSel <= FULL_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign regRdData          = q.rdData;
    assign slowOrEventOut1Out = 1'b0;
    assign slowOrEventOut1Oe  = q.drv1;
    assign ioOrEventOut2Out   = 1'b0;
    assign ioOrEventOut2Oe    = q.drv2;
    assign slowRequest        = !q.ctrl[CT_P1ALERT] && q.p1Sync[1];

    // ==========================================================
    // Checks
    property p_ccStart;
        @(posedge mclk) disable iff (!arst_n)
        cycleEnd && !singleBurst |=> q.ccCnt == CC_PULSE_LD;
    endproperty
    a_ccStart: assert property (p_ccStart) else $error("cycle-done pulse not loaded");

    property p_ccEnd;
        @(posedge mclk) disable iff (!arst_n)
        q.ccCnt == 8'h01 && !cycleEnd |=> !ccActive;
    endproperty
    a_ccEnd: assert property (p_ccEnd) else $error("cycle-done pulse too long");

    property p_ccNone;
        @(posedge mclk) disable iff (!arst_n)
        cycleEnd && singleBurst && !ccActive |=> !ccActive;
    endproperty
    a_ccNone: assert property (p_ccNone) else $error("pulse in single-channel burst");

    property p_causeAtEnd;
        @(posedge mclk) disable iff (!arst_n)
        !cycleEnd |=> (q.cause & ~$past(q.cause)) == 32'h00000000;
    endproperty
    a_causeAtEnd: assert property (p_causeAtEnd) else $error("cause set outside cycle end");

    property p_readClear;
        @(posedge mclk) disable iff (!arst_n)
        regReq.rdEn && regReq.addr == OFF_CAUSE && !cycleEnd |=> (q.cause & ~OVF_MASK) == 32'h00000000;
    endproperty
    a_readClear: assert property (p_readClear) else $error("cause not cleared by read");

    property p_ovfHold;
        @(posedge mclk) disable iff (!arst_n)
        !(refreshFull || refreshGeneral) |=> ($past(q.cause) & ~q.cause & OVF_MASK) == 32'h00000000;
    endproperty
    a_ovfHold: assert property (p_ovfHold) else $error("overflow cleared without refresh");

    property p_flag;
        @(posedge mclk) disable iff (!arst_n)
        regReq.rdEn && regReq.addr == OFF_BUS_SET |=> q.rdData[BS_ALERT] == ($past(q.cause) != 32'h00000000);
    endproperty
    a_flag: assert property (p_flag) else $error("general alert flag wrong");

    property p_pin1Ignore;
        @(posedge mclk) disable iff (!arst_n)
        q.ctrl[CT_P1ALERT] |-> !slowRequest;
    endproperty
    a_pin1Ignore: assert property (p_pin1Ignore) else $error("slow input seen in alert mode");

    property p_limEn;
        @(posedge mclk) disable iff (!arst_n)
        q.limEn == 20'h00000 |-> hitVec == 32'h00000000;
    endproperty
    a_limEn: assert property (p_limEn) else $error("disabled check raised a hit");

    property p_release;
        @(posedge mclk) disable iff (!arst_n)
        q.ctrl[CT_P1ALERT] && (q.cause & q.route1) != 32'h00000000 ##1 q.ctrl[CT_P1ALERT] |-> slowOrEventOut1Oe;
    endproperty
    a_release: assert property (p_release) else $error("pin one released with source set");
endmodule
`default_nettype wire

/* rtl/mal_limit_mem.sv */
// Limit store: 32 words of 24 bits, word address {channel, kind, high}.
// Assumes writes from the register port and reads from the sample path, same clock.
`timescale 1ns/10ps
`default_nettype none
module mal_limit_mem
(
    // Clock and reset
    input  wire  logic        mclk,
    input  wire  logic        arst_n,
    // Write side
    input  wire  logic        wrEn,
    input  wire  logic [4:0]  wrAddr,
    input  wire  logic [23:0] wrData,
    // Read side, both limits of one channel and kind
    input  wire  logic        rdEn,
    input  wire  logic [3:0]  rdAddr,
    output logic [23:0]       rdHi,
    output logic [23:0]       rdLo
);
    typedef struct packed {
        logic [31:0][23:0] mem;
        logic [23:0]       hi;
        logic [23:0]       lo;
    } mal_mem_st_t;

    mal_mem_st_t q;
    mal_mem_st_t d;

    // ==========================================================
    // Next state
    always_comb
    begin
        d = q;
        if (wrEn)
        begin
            d.mem[wrAddr] = wrData;
        end
        if (rdEn)
        begin
            d.hi = q.mem[{rdAddr, 1'b1}];
            d.lo = q.mem[{rdAddr, 1'b0}];
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            q <= '0;
        else
            q <= d;
    end

    assign rdHi = q.hi;
    assign rdLo = q.lo;
endmodule
`default_nettype wire

/* tb/mal_host_model.sv */
// Host model: register accesses and refresh strobes on the register port.
// Assumes the serial engine is outside and hands over one-cycle strobes on mclk.
`timescale 1ns/10ps
`default_nettype none
module mal_host_model
(
    // Clock
    input  wire logic            mclk,
    // Register port
    output var  mal_pkg::mal_regreq_t regReq,
    input  wire logic [31:0]     regRdData,
    // Refresh strobes
    output logic                 refreshFull,
    output logic                 refreshGeneral
);
    import mal_pkg::*;
    initial
    begin
        regReq = '0;
        refreshFull = 1'b0;
        refreshGeneral = 1'b0;
    end
    // ==========================================================
    // Accesses
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge mclk);
        regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        regReq.wrEn <= 1'b0;
        // Released data must not keep looking valid
        regReq.wdata <= ~d;
    end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
    begin
        @(posedge mclk);
        regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: regReq.wdata};
        @(posedge mclk);
        regReq.rdEn <= 1'b0;
        #1;
        d = regRdData;
    end
    endtask
    // Send-byte 00h arrives as refreshFull, general call as refreshGeneral
    task automatic refresh(input logic g);
    begin
        @(posedge mclk);
        if (g)
            refreshGeneral <= 1'b1;
        else
            refreshFull <= 1'b1;
        @(posedge mclk);
        refreshFull <= 1'b0;
        refreshGeneral <= 1'b0;
    end
    endtask
endmodule
`default_nettype wire

/* tb/measurement_alert_logic_test.sv */
// Self-checking bench of the alert logic, host model on the register port.
// Assumes a pull-up on alert pin two, pin one idling at the bench's slow level, and a sequencer driven by the bench.
`timescale 1ns/10ps
`default_nettype none
module measurement_alert_logic_test;
    import mal_pkg::*;
    logic mclk, arst_n, cycleEnd, refF, refG, slowLvl, slowReq;
    logic o1, oe1, o2, oe2;
    logic [2:0] actCh;
    logic [31:0] rdData, v;
    mal_regreq_t req;
    mal_sample_t sample;
    mal_accfill_t [3:0] accFill;
    int errors, n_compared, n;
    wire pin1 = oe1 ? o1 : slowLvl;
    wire pin2 = oe2 ? o2 : 1'b1;
    mal_host_model host (.mclk(mclk), .regReq(req), .regRdData(rdData),
        .refreshFull(refF), .refreshGeneral(refG));
    mal_alert_top DUT (.mclk(mclk), .arst_n(arst_n), .regReq(req), .regRdData(rdData),
        .sample(sample), .cycleEnd(cycleEnd), .activeChannels(actCh), .accFill(accFill),
        .refreshFull(refF), .refreshGeneral(refG), .slowOrEventOut1In(pin1),
        .slowOrEventOut1Out(o1), .slowOrEventOut1Oe(oe1), .ioOrEventOut2In(pin2),
        .ioOrEventOut2Out(o2), .ioOrEventOut2Oe(oe2), .slowRequest(slowReq));
    // ==========================================================
    // Helpers
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
    begin
        n_compared++;
        if (seen !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", s, e, seen);
        end
    end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
    begin
        host.rd(a, v);
        chk("reg", v, e);
    end
    endtask
    // Kind 3 is ignored, so cyc(0,3,0) is a bare cycle end
    task automatic cyc(input logic [1:0] c, input logic [1:0] k, input logic [23:0] x);
    begin
        @(posedge mclk);
        sample <= '{valid: 1'b1, ch: c, kind: k, value: x};
        @(posedge mclk);
        sample.valid <= 1'b0;
        cycleEnd <= 1'b1;
        @(posedge mclk);
        cycleEnd <= 1'b0;
        @(posedge mclk);
        #1;
    end
    endtask
    task automatic give_verdict;
    begin
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_limits;
    begin
        rc(8'h30, 0);
        rc(8'h41, 0);
        host.wr(8'h41, 100);
        host.wr(8'h24, 1);
        host.wr(8'h21, 1);
        host.wr(8'h22, 1);
        host.wr(8'h23, 4);
        cyc(0, 0, 100);
        rc(OFF_CAUSE, 0);
        @(posedge mclk);
        sample <= '{valid: 1'b1, ch: 2'h0, kind: 2'h0, value: 24'h65};
        @(posedge mclk);
        sample.valid <= 1'b0;
        rc(OFF_CAUSE, 0);
        cyc(0, 3, 0);
        chk("oe1", oe1, 1);
        chk("oe2", oe2, 1);
        // Pin two level needs two synchroniser stages before the read sees it low
        repeat (2) @(posedge mclk);
        rc(OFF_BUS_SET, 32'h20);
        rc(OFF_CAUSE, 1);
        // Pin drive is registered, so the release shows one cycle after the clear
        @(posedge mclk);
        #1;
        chk("oe1", oe1, 0);
        chk("oe2", oe2, 0);
        host.wr(8'h40, 32'hFFFB);
        host.wr(8'h24, 2);
        cyc(0, 0, 24'hFFFFFB);
        rc(OFF_CAUSE, 0);
        cyc(0, 0, 24'hFFFFFA);
        chk("oe1", oe1, 0);
        rc(OFF_CAUSE, 2);
        host.wr(8'h45, 1000);
        host.wr(8'h24, 32'h10);
        cyc(0, 2, 24'hFFFC18);
        rc(OFF_CAUSE, 0);
        cyc(0, 2, 24'hFFFC17);
        rc(OFF_CAUSE, 32'h10);
        host.wr(8'h49, 10);
        host.wr(8'h24, 1);
        cyc(1, 0, 50);
        rc(OFF_CAUSE, 0);
        host.wr(8'h24, 32'h20);
        cyc(1, 0, 50);
        rc(OFF_CAUSE, 32'h100);
    end
    endtask
    task automatic t_count;
    begin
        host.wr(8'h24, 1);
        host.wr(OFF_COUNTS, 2);
        cyc(0, 0, 101);
        cyc(0, 0, 101);
        cyc(0, 0, 50);
        cyc(0, 0, 101);
        cyc(0, 0, 101);
        rc(OFF_CAUSE, 0);
        cyc(0, 0, 101);
        rc(OFF_CAUSE, 1);
        cyc(0, 0, 101);
        rc(OFF_CAUSE, 1);
        host.wr(OFF_COUNTS, 0);
        host.wr(8'h24, 0);
    end
    endtask
    task automatic t_pulse;
    begin
        host.wr(OFF_CTRL, 5);
        cyc(0, 3, 0);
        n = 1;
        while (oe1 === 1'b1 && n < 400)
        begin
            @(posedge mclk);
            #1;
            if (oe1 === 1'b1)
                n++;
        end
        chk("pulse", n, CC_PULSE_CYC);
        rc(OFF_CAUSE, 0);
        host.wr(OFF_CTRL, 8'h27);
        actCh <= 3'h1;
        cyc(0, 3, 0);
        chk("oe1", oe1, 0);
        chk("oe2", oe2, 0);
        actCh <= 3'h2;
        cyc(0, 3, 0);
        chk("oe1", oe1, 1);
        chk("oe2", oe2, 1);
        host.wr(OFF_CTRL, 0);
    end
    endtask
    task automatic t_accum;
    begin
        host.wr(OFF_FULL_SEL, 1);
        accFill[0].accTop <= 4'hE;
        cyc(0, 3, 0);
        accFill[0].accTop <= 4'h0;
        rc(OFF_CAUSE, 32'h20);
        for (int g = 0; g < 2; g++)
        begin
            accFill[0].accSat <= 1'b1;
            cyc(0, 3, 0);
            accFill[0].accSat <= 1'b0;
            rc(OFF_CAUSE, 32'h80);
            rc(OFF_CAUSE, 32'h80);
            host.refresh(g[0]);
            rc(OFF_CAUSE, 0);
        end
    end
    endtask
    task automatic t_pins;
    begin
        host.wr(OFF_CTRL, 8'h18);
        host.wr(OFF_BUS_SET, 0);
        repeat (6) @(posedge mclk);
        #1;
        chk("oe2", oe2, 1);
        rc(OFF_BUS_SET, 0);
        host.wr(OFF_BUS_SET, 32'h40);
        repeat (6) @(posedge mclk);
        #1;
        chk("oe2", oe2, 0);
        rc(OFF_BUS_SET, 32'hC0);
        host.wr(OFF_CTRL, 0);
        slowLvl <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        chk("slow", slowReq, 1);
        host.wr(OFF_CTRL, 4);
        repeat (4) @(posedge mclk);
        #1;
        chk("slow", slowReq, 0);
    end
    endtask
    // ==========================================================
    // Run
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial
    begin
        // Whole run is under 3000 cycles
        #(CLK_NS * 20000);
        errors++;
        give_verdict();
    end
    initial
    begin
        errors = 0;
        n_compared = 0;
        arst_n = 1'b0;
        cycleEnd = 1'b0;
        sample = '0;
        accFill = '0;
        actCh = 3'h4;
        slowLvl = 1'b0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        #1;
        chk("oe1", oe1, 0);
        rc(OFF_BUS_SET, 0);
        t_limits();
        t_count();
        t_pulse();
        t_accum();
        t_pins();
        give_verdict();
    end
endmodule
`default_nettype wire
